// >>> core/ea_calc.sv
`include "oag_consts.svh"

module ea_calc
  import oag_pkg::*;
(
  // Address arithmetic
  ea_if.calc ea
);

  // ----------------------------------------
  // Step size
  // ----------------------------------------
  function automatic word32_t step_of(input op_size_t size, input logic [2:0] rnum);
    case (size)
      SIZE_BYTE: return (rnum == `SP_NUM) ? `STEP_WORD : `STEP_BYTE;
      SIZE_WORD: return `STEP_WORD;
      default: return `STEP_LONG;
    endcase
  endfunction : step_of

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  assign ea.idx_is_addr = ea.ext_hi[`IDX_DA_BIT];
  assign ea.idx_num = ea.ext_hi[`IDX_NUM_HI:`IDX_NUM_LO];
  assign ea.step = step_of(ea.size, ea.rnum);

  always_comb
  begin
    ea.addr = ea.base;
    ea.ext_count = `EXT_NONE;
    ea.pc_rel = 1'b0;
    ea.illegal = 1'b0;
    ea.imm = 1'b0;
    ea.status_sel = 1'b0;
    case (ea.mode)
      MODE_DREG, MODE_AREG:
      begin
        ea.addr = '0;
      end
      MODE_IND, MODE_POST:
      begin
        ea.addr = ea.base;
      end
      MODE_PRE:
      begin
        ea.addr = ea.base - ea.step;
      end
      MODE_DISP:
      begin
        ea.ext_count = `EXT_ONE;
        ea.addr = ea.base + sext16(ea.ext_hi);
      end
      MODE_INDEX:
      begin
        ea.ext_count = `EXT_ONE;
        ea.addr = ea.base + sext8(ea.ext_hi[`B_HI:0]) + ea.index_val;
      end
      default:
      begin
        case (ea.rnum)
          `SUB_ABS_SHORT:
          begin
            ea.ext_count = `EXT_ONE;
            ea.addr = sext16(ea.ext_hi);
          end
          `SUB_ABS_LONG:
          begin
            ea.ext_count = `EXT_TWO;
            ea.addr = {ea.ext_hi, ea.ext_lo};
          end
          `SUB_PC_DISP:
          begin
            ea.ext_count = `EXT_ONE;
            ea.pc_rel = 1'b1;
            ea.addr = ea.ext_pos + sext16(ea.ext_hi);
          end
          `SUB_PC_INDEX:
          begin
            ea.ext_count = `EXT_ONE;
            ea.pc_rel = 1'b1;
            ea.addr = ea.ext_pos + sext8(ea.ext_hi[`B_HI:0]) + ea.index_val;
          end
          `SUB_IMMEDIATE:
          begin
            // The state register form carries no extension of its own
            ea.status_sel = ea.sr_op;
            ea.imm = !ea.sr_op;
            if (!ea.sr_op)
            begin
              ea.ext_count = (ea.size == SIZE_LONG) ? `EXT_TWO : `EXT_ONE;
            end
          end
          default:
          begin
            ea.illegal = 1'b1;
          end
        endcase
      end
    endcase
  end

endmodule : ea_calc

// >>> core/ea_if.sv
interface ea_if;
  import oag_pkg::*;

  ea_mode_t mode;
  logic [2:0] rnum;
  op_size_t size;
  logic sr_op;
  word16_t ext_hi;
  word16_t ext_lo;
  word32_t ext_pos;
  word32_t base;
  word32_t index_val;
  word32_t addr;
  word32_t step;
  logic [1:0] ext_count;
  logic pc_rel;
  logic illegal;
  logic imm;
  logic status_sel;
  logic idx_is_addr;
  logic [2:0] idx_num;

  modport seq
  (
    output mode, rnum, size, sr_op, ext_hi, ext_lo, ext_pos, base, index_val,
    input addr, step, ext_count, pc_rel, illegal, imm, status_sel, idx_is_addr, idx_num
  );

  modport calc
  (
    input mode, rnum, size, sr_op, ext_hi, ext_lo, ext_pos, base, index_val,
    output addr, step, ext_count, pc_rel, illegal, imm, status_sel, idx_is_addr, idx_num
  );

endinterface : ea_if

// >>> core/oag_consts.svh
`ifndef OAG_CONSTS_SVH
`define OAG_CONSTS_SVH

// ----------------------------------------
// Operation word field positions
// ----------------------------------------
`define EA_MODE_HI 5
`define EA_MODE_LO 3
`define EA_REG_HI 2
`define EA_REG_LO 0

// ----------------------------------------
// Special mode register-field codes and the stack pointer register number
// ----------------------------------------
`define SUB_ABS_SHORT 3'h0
`define SUB_ABS_LONG 3'h1
`define SUB_PC_DISP 3'h2
`define SUB_PC_INDEX 3'h3
`define SUB_IMMEDIATE 3'h4
`define SP_NUM 3'h7

// ----------------------------------------
// Index extension word layout
// ----------------------------------------
`define IDX_DA_BIT 15
`define IDX_NUM_HI 14
`define IDX_NUM_LO 12
`define IDX_LONG_BIT 11

// ----------------------------------------
// Operand widths, masks and steps
// ----------------------------------------
`define B_HI 7
`define W_HI 15
`define L_HI 31
`define UP_LO 16
`define LANE_ODD_BIT 0
`define MASK_BYTE 32'h0000_00FF
`define MASK_WORD 32'h0000_FFFF
`define MASK_LONG 32'hFFFF_FFFF
`define STEP_BYTE 32'h0000_0001
`define STEP_WORD 32'h0000_0002
`define STEP_LONG 32'h0000_0004
`define LONG_SECOND_OFS 32'h0000_0002
`define EXT_NONE 2'h0
`define EXT_ONE 2'h1
`define EXT_TWO 2'h2

`endif

// >>> core/oag_pkg.sv
package oag_pkg;

  typedef logic [31:0] word32_t;
  typedef logic [15:0] word16_t;

  typedef enum logic [2:0]
  {
    MODE_DREG = 3'b000,
    MODE_AREG = 3'b001,
    MODE_IND = 3'b010,
    MODE_POST = 3'b011,
    MODE_PRE = 3'b100,
    MODE_DISP = 3'b101,
    MODE_INDEX = 3'b110,
    MODE_SPECIAL = 3'b111
  } ea_mode_t;

  typedef enum logic [1:0]
  {
    SIZE_BYTE = 2'b00,
    SIZE_WORD = 2'b01,
    SIZE_LONG = 2'b10
  } op_size_t;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_EXT = 2'b01,
    ST_CALC = 2'b10,
    ST_BUS = 2'b11
  } seq_state_t;

  function automatic word32_t sext16(input word16_t v);
    return word32_t'($signed(v));
  endfunction : sext16

  function automatic word32_t sext8(input logic [7:0] v);
    return word32_t'($signed(v));
  endfunction : sext8

endpackage : oag_pkg

// >>> core/operand_address_generation.sv
// Summary of operation
// - Data registers are 32 bits; byte, word, long use bits 7..0, 15..0, 31..0.
// - Byte or word access leaves upper data register bits unread and unchanged.
// - Address register source gives low 16 bits for word, all 32 for long.
// - Address register destination writes all 32 bits; word data is sign-extended.
// - Even address holds the high byte of a word, odd address the low byte.
// - Word and long accesses are only issued at even addresses.
// - Long word at n: high word at n, low word at n plus two.
// - Mode, register field, size and state register flag fix the number of extension words.
// - Writes are data space; reads are data space except PC-relative reads.
// - Effective address field is a 3-bit mode plus a 3-bit register.
// - Postincrement uses the register, then adds 1, 2 or 4 by size.
// - Stack pointer byte postincrement adds 2 to keep word alignment.
// - Predecrement subtracts 1, 2 or 4 first; stack pointer byte subtracts 2.
// - Displacement mode adds a sign-extended 16-bit extension word to the register.
// - Index mode adds sign-extended low byte and index register to the register.
// - Absolute short takes one extension word, sign-extended.
// - Absolute long joins two extension words, first word high.
// - PC displacement adds sign-extended word to its own address; program reference.
// - PC index adds low byte and index to extension address; program reference.
// - Immediate byte is low byte, word one extension, long two words high first.
// - Memory modes other than PC-relative tag data references, but jumps tag program references.
// - Only the state register operations may select it through the address field.
// - Modes 000-110 are register modes; 111 uses register field for specials.
// - Address register seven is supervisor or user stack pointer by state bit.
`include "oag_consts.svh"

module operand_address_generation
  import oag_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Instruction from the sequencer
  input wire logic start,
  input wire word16_t op_word,
  input wire op_size_t op_size,
  input wire logic op_jump,
  input wire logic op_write,
  input wire logic op_state_reg,
  input wire logic supervisor,
  input wire word32_t write_data,
  // Extension words
  input wire logic ext_valid,
  input wire word16_t ext_word,
  input wire word32_t ext_word_addr,
  output logic ext_req,
  // Register port
  input wire logic rf_wr_en,
  input wire logic rf_wr_addr,
  input wire logic [2:0] rf_wr_num,
  input wire op_size_t rf_wr_size,
  input wire word32_t rf_wr_data,
  input wire logic rf_rd_addr,
  input wire logic [2:0] rf_rd_num,
  input wire op_size_t rf_rd_size,
  output word32_t rf_rd_data,
  // Memory bus
  output logic bus_req,
  output logic bus_write,
  output word32_t bus_addr,
  output logic bus_upper,
  output logic bus_lower,
  output logic bus_program,
  output word16_t bus_wdata,
  input wire logic bus_ack,
  input wire word16_t bus_rdata,
  // Result
  output logic done,
  output word32_t operand,
  output word32_t ea_addr,
  output logic ref_program,
  output logic ea_illegal,
  output logic addr_error,
  output logic status_sel
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    seq_state_t st;
    logic [7:0][31:0] dreg;
    logic [7:0][31:0] areg;
    word32_t supervisor_stack_pointer;
    ea_mode_t mode;
    logic [2:0] rnum;
    op_size_t size;
    logic jump;
    logic wr;
    logic sr_op;
    word16_t ext_hi;
    word16_t ext_lo;
    word32_t ext_pos;
    logic [1:0] ext_got;
    logic second;
    word32_t wdata;
    logic ext_req;
    logic bus_req;
    logic bus_write;
    word32_t bus_addr;
    logic bus_upper;
    logic bus_lower;
    logic bus_program;
    word16_t bus_wdata;
    logic done;
    word32_t operand;
    word32_t ea_addr;
    logic ref_program;
    logic illegal;
    logic addr_error;
    logic status_sel;
    word32_t rd_data;
  } core_state_t;

  core_state_t state_reg;
  core_state_t state_next;
  word32_t idx_raw;

  ea_if ea_bus();

  ea_calc u_calc
  (
    .ea(ea_bus)
  );

  // ----------------------------------------
  // Register file helpers
  // ----------------------------------------
  function automatic word32_t size_mask(input op_size_t size);
    case (size)
      SIZE_BYTE: return `MASK_BYTE;
      SIZE_WORD: return `MASK_WORD;
      default: return `MASK_LONG;
    endcase
  endfunction : size_mask

  function automatic word32_t get_reg(input core_state_t s, input logic is_addr, input logic [2:0] num,
                                      input logic sup);
    if (!is_addr)
    begin
      return s.dreg[num];
    end
    // Only the active stack pointer is reachable as register seven
    if (num == `SP_NUM && sup)
    begin
      return s.supervisor_stack_pointer;
    end
    return s.areg[num];
  endfunction : get_reg

  function automatic core_state_t put_reg(input core_state_t s, input logic is_addr, input logic [2:0] num,
                                          input logic sup, input op_size_t size, input word32_t v);
    core_state_t t;
    word32_t full;
    t = s;
    full = (size == SIZE_LONG) ? v : sext16(v[`W_HI:0]);
    if (!is_addr)
    begin
      t.dreg[num] = (s.dreg[num] & ~size_mask(size)) | (v & size_mask(size));
    end
    else if (num == `SP_NUM && sup)
    begin
      t.supervisor_stack_pointer = full;
    end
    else
    begin
      t.areg[num] = full;
    end
    return t;
  endfunction : put_reg

  function automatic word32_t read_sized(input core_state_t s, input logic is_addr, input logic [2:0] num,
                                         input logic sup, input op_size_t size);
    word32_t m;
    m = size_mask(size);
    if (is_addr && size == SIZE_BYTE)
    begin
      m = `MASK_WORD;
    end
    return get_reg(s, is_addr, num, sup) & m;
  endfunction : read_sized

  // ----------------------------------------
  // Address calculator inputs
  // ----------------------------------------
  assign ea_bus.mode = state_reg.mode;
  assign ea_bus.rnum = state_reg.rnum;
  assign ea_bus.size = state_reg.size;
  assign ea_bus.sr_op = state_reg.sr_op;
  assign ea_bus.ext_hi = state_reg.ext_hi;
  assign ea_bus.ext_lo = state_reg.ext_lo;
  assign ea_bus.ext_pos = state_reg.ext_pos;
  assign ea_bus.base = get_reg(state_reg, 1'b1, state_reg.rnum, supervisor);
  assign idx_raw = get_reg(state_reg, ea_bus.idx_is_addr, ea_bus.idx_num, supervisor);
  assign ea_bus.index_val = state_reg.ext_hi[`IDX_LONG_BIT] ? idx_raw : sext16(idx_raw[`W_HI:0]);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    state_next = state_reg;
    state_next.done = 1'b0;
    state_next.rd_data = read_sized(state_reg, rf_rd_addr, rf_rd_num, supervisor, rf_rd_size);
    if (rf_wr_en)
    begin
      state_next = put_reg(state_next, rf_wr_addr, rf_wr_num, supervisor, rf_wr_size, rf_wr_data);
    end
    case (state_reg.st)
      ST_IDLE:
      begin
        if (start)
        begin
          state_next.mode = ea_mode_t'(op_word[`EA_MODE_HI:`EA_MODE_LO]);
          state_next.rnum = op_word[`EA_REG_HI:`EA_REG_LO];
          state_next.size = op_size;
          state_next.jump = op_jump;
          state_next.wr = op_write;
          state_next.sr_op = op_state_reg;
          state_next.wdata = write_data;
          state_next.ext_got = `EXT_NONE;
          state_next.illegal = 1'b0;
          state_next.addr_error = 1'b0;
          state_next.status_sel = 1'b0;
          state_next.st = ST_EXT;
        end
      end
      ST_EXT:
      begin
        // Word count comes from the latched mode, register field, size and state register flag only
        if (state_reg.ext_got == ea_bus.ext_count)
        begin
          state_next.ext_req = 1'b0;
          state_next.st = ST_CALC;
        end
        else if (state_reg.ext_req && ext_valid)
        begin
          if (state_reg.ext_got == `EXT_NONE)
          begin
            state_next.ext_hi = ext_word;
            state_next.ext_pos = ext_word_addr;
          end
          else
          begin
            state_next.ext_lo = ext_word;
          end
          state_next.ext_got = state_reg.ext_got + `EXT_ONE;
          state_next.ext_req = (state_reg.ext_got + `EXT_ONE) != ea_bus.ext_count;
        end
        else
        begin
          state_next.ext_req = 1'b1;
        end
      end
      ST_CALC:
      begin
        state_next.ea_addr = ea_bus.addr;
        state_next.illegal = ea_bus.illegal;
        state_next.status_sel = ea_bus.status_sel;
        state_next.ref_program = ea_bus.pc_rel || state_reg.jump;
        state_next.st = ST_IDLE;
        state_next.done = 1'b1;
        if (ea_bus.illegal || ea_bus.status_sel || state_reg.jump)
        begin
          state_next.operand = '0;
        end
        else if (state_reg.mode == MODE_DREG || state_reg.mode == MODE_AREG)
        begin
          if (state_reg.wr)
          begin
            state_next = put_reg(state_next, state_reg.mode == MODE_AREG, state_reg.rnum, supervisor,
                                 state_reg.size, state_reg.wdata);
          end
          else
          begin
            state_next.operand = read_sized(state_reg, state_reg.mode == MODE_AREG, state_reg.rnum,
                                            supervisor, state_reg.size);
          end
        end
        else if (ea_bus.imm)
        begin
          state_next.operand = {state_reg.ext_hi, state_reg.ext_lo};
          if (state_reg.size != SIZE_LONG)
          begin
            state_next.operand = word32_t'(state_reg.ext_hi) & size_mask(state_reg.size);
          end
        end
        else
        begin
          if (state_reg.mode == MODE_POST)
          begin
            state_next = put_reg(state_next, 1'b1, state_reg.rnum, supervisor, SIZE_LONG,
                                 ea_bus.base + ea_bus.step);
          end
          else if (state_reg.mode == MODE_PRE)
          begin
            state_next = put_reg(state_next, 1'b1, state_reg.rnum, supervisor, SIZE_LONG, ea_bus.addr);
          end
          // An odd multi-byte address is refused before any bus cycle
          if (state_reg.size != SIZE_BYTE && ea_bus.addr[`LANE_ODD_BIT])
          begin
            state_next.addr_error = 1'b1;
          end
          else
          begin
            state_next.done = 1'b0;
            state_next.st = ST_BUS;
            state_next.second = 1'b0;
            state_next.bus_req = 1'b1;
            state_next.bus_addr = ea_bus.addr;
            state_next.bus_write = state_reg.wr;
            state_next.bus_program = ea_bus.pc_rel && !state_reg.wr;
            state_next.bus_upper = (state_reg.size != SIZE_BYTE) || !ea_bus.addr[`LANE_ODD_BIT];
            state_next.bus_lower = (state_reg.size != SIZE_BYTE) || ea_bus.addr[`LANE_ODD_BIT];
            case (state_reg.size)
              SIZE_BYTE: state_next.bus_wdata = {state_reg.wdata[`B_HI:0], state_reg.wdata[`B_HI:0]};
              SIZE_WORD: state_next.bus_wdata = state_reg.wdata[`W_HI:0];
              default: state_next.bus_wdata = state_reg.wdata[`L_HI:`UP_LO];
            endcase
          end
        end
      end
      ST_BUS:
      begin
        if (bus_ack)
        begin
          if (state_reg.size == SIZE_LONG && !state_reg.second)
          begin
            state_next.operand[`L_HI:`UP_LO] = bus_rdata;
            state_next.second = 1'b1;
            state_next.bus_addr = state_reg.bus_addr + `LONG_SECOND_OFS;
            state_next.bus_wdata = state_reg.wdata[`W_HI:0];
          end
          else
          begin
            if (state_reg.size == SIZE_LONG)
            begin
              state_next.operand[`W_HI:0] = bus_rdata;
            end
            else if (state_reg.size == SIZE_WORD)
            begin
              state_next.operand = word32_t'(bus_rdata);
            end
            else
            begin
              state_next.operand = state_reg.bus_addr[`LANE_ODD_BIT] ? word32_t'(bus_rdata[`B_HI:0])
                                                                    : word32_t'(bus_rdata[`W_HI:`B_HI + 1]);
            end
            state_next.bus_req = 1'b0;
            state_next.done = 1'b1;
            state_next.st = ST_IDLE;
          end
        end
      end
      default:
      begin
        state_next.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign ext_req = state_reg.ext_req;
  assign rf_rd_data = state_reg.rd_data;
  assign bus_req = state_reg.bus_req;
  assign bus_write = state_reg.bus_write;
  assign bus_addr = state_reg.bus_addr;
  assign bus_upper = state_reg.bus_upper;
  assign bus_lower = state_reg.bus_lower;
  assign bus_program = state_reg.bus_program;
  assign bus_wdata = state_reg.bus_wdata;
  assign done = state_reg.done;
  assign operand = state_reg.operand;
  assign ea_addr = state_reg.ea_addr;
  assign ref_program = state_reg.ref_program;
  assign ea_illegal = state_reg.illegal;
  assign addr_error = state_reg.addr_error;
  assign status_sel = state_reg.status_sel;

endmodule : operand_address_generation

// >>> sim/oag_mem_model.sv
module oag_mem_model
(
  // Bus side
  input wire logic clk,
  input wire logic rst_b,
  input wire logic bus_req,
  input wire logic [31:0] bus_addr,
  input wire integer slow,
  output logic bus_ack,
  output logic [15:0] bus_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  // Data between acks toggles so a late sample never matches
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bus_ack <= 1'b0;
      cnt <= 0;
      bus_rdata <= 16'h0000;
    end
    else if (bus_ack)
    begin
      bus_ack <= 1'b0;
      cnt <= 0;
      bus_rdata <= ~bus_rdata;
    end
    else if (bus_req && cnt >= slow)
    begin
      bus_ack <= 1'b1;
      bus_rdata <= bus_addr[15:0] ^ 16'hA55A;
    end
    else
    begin
      cnt <= cnt + (bus_req ? 1 : 0);
      bus_rdata <= ~bus_rdata;
    end
  end
endmodule : oag_mem_model

// >>> sim/oag_monitor.sv
module oag_monitor
  import oag_pkg::*;
(
  // Watched ports
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire word16_t op_word,
  input wire logic op_jump,
  input wire logic bus_req,
  input wire logic bus_write,
  input wire word32_t bus_addr,
  input wire logic bus_upper,
  input wire logic bus_lower,
  input wire logic bus_program,
  input wire logic bus_ack,
  input wire logic done,
  input wire logic ea_illegal,
  input wire logic ref_program
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // ----
  // Job tracking
  // ----
  logic busy_reg, jump_reg, pc_reg;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busy_reg <= 1'b0;
      jump_reg <= 1'b0;
      pc_reg <= 1'b0;
    end
    else if (start && (!busy_reg || done))
    begin
      busy_reg <= 1'b1;
      jump_reg <= op_jump;
      pc_reg <= op_word[5:1] == 5'h1D;
    end
    else if (done)
      busy_reg <= 1'b0;
  end
  sequence s_take;
    start && (!busy_reg || done);
  endsequence
  sequence s_bad_ea;
    op_word[5:3] == 3'h7 && op_word[2:0] > 3'h4;
  endsequence
  property p_even_word;
    bus_req && bus_upper && bus_lower |-> !bus_addr[0];
  endproperty
  a_even_word: assert property (p_even_word) else $error("word access at odd address");
  property p_byte_lane;
    bus_req && !bus_write && (bus_upper ^ bus_lower) |-> bus_lower == bus_addr[0];
  endproperty
  a_byte_lane: assert property (p_byte_lane) else $error("byte lane wrong");
  property p_long_step;
    bus_req && bus_ack ##1 bus_req |-> bus_addr == $past(bus_addr) + 32'h0000_0002;
  endproperty
  a_long_step: assert property (p_long_step) else $error("second word not at n+2");
  property p_hold;
    bus_req && !bus_ack |=> bus_req && $stable(bus_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("bus request dropped early");
  property p_write_data;
    bus_req && bus_write |-> !bus_program;
  endproperty
  a_write_data: assert property (p_write_data) else $error("write tagged program");
  property p_prog_tag;
    bus_req && !bus_write |-> bus_program == pc_reg;
  endproperty
  a_prog_tag: assert property (p_prog_tag) else $error("read space tag wrong");
  property p_jump_nobus;
    busy_reg && jump_reg |-> !bus_req;
  endproperty
  a_jump_nobus: assert property (p_jump_nobus) else $error("jump made bus access");
  property p_jump_prog;
    done && jump_reg |-> ref_program;
  endproperty
  a_jump_prog: assert property (p_jump_prog) else $error("jump not program ref");
  property p_illegal;
    s_take ##0 s_bad_ea |-> ##[1:3] (done && ea_illegal);
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal mode not flagged");
endmodule : oag_monitor

// >>> sim/operand_address_generation_bench.sv
module operand_address_generation_bench;
  import oag_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_b = 1'b0, done, ref_program, ea_illegal, addr_error, status_sel;
  logic start = 1'b0, op_jump = 1'b0, op_write = 1'b0, supervisor = 1'b0;
  logic rf_wr_en = 1'b0, rf_wr_addr = 1'b0, rf_rd_addr = 1'b0, op_state_reg = 1'b0;
  logic [2:0] rf_wr_num = 3'h0, rf_rd_num = 3'h0;
  op_size_t op_size = SIZE_BYTE, rf_wr_size = SIZE_LONG, rf_rd_size = SIZE_LONG;
  word16_t op_word = 16'h0000, ext_word, bus_wdata, bus_rdata, ext_a [0:1] = '{16'h0000, 16'h0000};
  word32_t rf_wr_data = 32'h0, ext_word_addr, rf_rd_data, bus_addr, operand, ea_addr;
  logic ext_req, bus_req, bus_write, bus_upper, bus_lower, bus_program, bus_ack;
  int ext_i = 0, slow = 0, n_mismatch = 0, n_compared = 0, cycles = 0;
  assign ext_word = ext_a[ext_i[0]];
  assign ext_word_addr = 32'h0000_1000 + 32'(ext_i * 2);
  always #50 clk = ~clk;
  operand_address_generation DUT (.clk, .rst_b, .start, .op_word, .op_size, .op_jump, .op_write,
    .op_state_reg, .supervisor, .write_data(32'hC3A5_5A3C), .ext_valid(1'b1), .ext_word,
    .ext_word_addr, .ext_req, .rf_wr_en, .rf_wr_addr, .rf_wr_num, .rf_wr_size, .rf_wr_data,
    .rf_rd_addr, .rf_rd_num, .rf_rd_size, .rf_rd_data, .bus_req, .bus_write, .bus_addr, .bus_upper,
    .bus_lower, .bus_program, .bus_wdata, .bus_ack, .bus_rdata, .done, .operand, .ea_addr,
    .ref_program, .ea_illegal, .addr_error, .status_sel);
  oag_mem_model MEM (.clk, .rst_b, .bus_req, .bus_addr, .slow, .bus_ack, .bus_rdata);
  function automatic word32_t m(input word32_t a);
    return {16'h0000, a[15:0] ^ 16'hA55A};
  endfunction : m
  task conclude;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude
  always @(posedge clk)
  begin
    cycles++;
    if (ext_req)
      ext_i <= ext_i + 1;
    if (cycles == 3000)
    begin
      n_mismatch++;
      conclude();
    end
  end
  task chk(input word32_t got, input word32_t exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wreg(input logic a, input logic [2:0] n, input op_size_t s, input word32_t d);
    @(posedge clk);
    {rf_wr_en, rf_wr_addr, rf_wr_num, rf_wr_data} <= {1'b1, a, n, d};
    rf_wr_size <= s;
    @(posedge clk);
    rf_wr_en <= 1'b0;
  endtask : wreg
  task rreg(input logic a, input logic [2:0] n, input op_size_t s, input word32_t exp);
    @(posedge clk);
    {rf_rd_addr, rf_rd_num} <= {a, n};
    rf_rd_size <= s;
    @(posedge clk);
    #1 chk(rf_rd_data, exp);
  endtask : rreg
  task job(input logic [5:0] ea, input op_size_t s, input logic j, input logic w, input word32_t e);
    ext_a = '{e[31:16], e[15:0]};
    ext_i = 0;
    @(posedge clk);
    {start, op_word, op_jump, op_write} <= {1'b1, 10'h000, ea, j, w};
    op_size <= s;
    @(posedge clk);
    start <= 1'b0;
    for (int k = 0; k < 40 && done !== 1'b1; k++)
      @(posedge clk) #1;
    chk(32'(done), 32'h1);
  endtask : job
  task t_regs;
    wreg(1'b0, 3'h1, SIZE_LONG, 32'h1234_5678);
    wreg(1'b0, 3'h1, SIZE_BYTE, 32'hFFFF_FFAA);
    rreg(1'b0, 3'h1, SIZE_LONG, 32'h1234_56AA);
    rreg(1'b0, 3'h1, SIZE_BYTE, 32'h0000_00AA);
    wreg(1'b1, 3'h2, SIZE_WORD, 32'h0000_8000);
    rreg(1'b1, 3'h2, SIZE_LONG, 32'hFFFF_8000);
    rreg(1'b1, 3'h2, SIZE_WORD, 32'h0000_8000);
    $display("test regs end");
  endtask : t_regs
  task t_modes;
    wreg(1'b1, 3'h0, SIZE_LONG, 32'h0000_4000);
    wreg(1'b0, 3'h3, SIZE_LONG, 32'h0000_0020);
    slow = 3;
    job(6'h28, SIZE_WORD, 1'b0, 1'b0, 32'hFFFE_0000);
    chk(ea_addr, 32'h0000_3FFE);
    chk(operand, m(32'h3FFE));
    chk(32'(ref_program), 32'h0);
    job(6'h30, SIZE_LONG, 1'b0, 1'b0, 32'h38F0_0000);
    chk(operand, {m(32'h4010) << 16} | m(32'h4012));
    slow = 0;
    job(6'h3A, SIZE_WORD, 1'b0, 1'b0, 32'h0010_0000);
    chk(ea_addr, 32'h0000_1010);
    job(6'h3B, SIZE_WORD, 1'b0, 1'b0, 32'h8802_0000);
    chk(ea_addr, 32'h0000_5002);
    chk(32'(ref_program), 32'h1);
    job(6'h38, SIZE_WORD, 1'b0, 1'b0, 32'h8000_0000);
    chk(ea_addr, 32'hFFFF_8000);
    job(6'h39, SIZE_WORD, 1'b0, 1'b0, 32'h0002_0004);
    chk(ea_addr, 32'h0002_0004);
    job(6'h3C, SIZE_BYTE, 1'b0, 1'b0, 32'h12AB_0000);
    chk(operand, 32'h0000_00AB);
    job(6'h3C, SIZE_LONG, 1'b0, 1'b0, 32'h1234_5678);
    chk(operand, 32'h1234_5678);
    $display("test modes end");
  endtask : t_modes
  task t_stack;
    @(posedge clk) supervisor <= 1'b1;
    wreg(1'b1, 3'h7, SIZE_LONG, 32'h0000_6000);
    job(6'h1F, SIZE_BYTE, 1'b0, 1'b0, 32'h0);
    rreg(1'b1, 3'h7, SIZE_LONG, 32'h0000_6002);
    @(posedge clk) supervisor <= 1'b0;
    wreg(1'b1, 3'h7, SIZE_LONG, 32'h0000_7000);
    @(posedge clk) supervisor <= 1'b1;
    rreg(1'b1, 3'h7, SIZE_LONG, 32'h0000_6002);
    wreg(1'b1, 3'h1, SIZE_LONG, 32'h0000_3000);
    job(6'h21, SIZE_LONG, 1'b0, 1'b0, 32'h0);
    chk(ea_addr, 32'h0000_2FFC);
    job(6'h19, SIZE_WORD, 1'b0, 1'b1, 32'h0);
    rreg(1'b1, 3'h1, SIZE_LONG, 32'h0000_2FFE);
    $display("test stack end");
  endtask : t_stack
  task t_faults;
    for (int r = 5; r < 8; r++)
    begin
      job({3'h7, 3'(r)}, SIZE_WORD, 1'b0, 1'b0, 32'h0);
      chk(32'(ea_illegal), 32'h1);
    end
    job(6'h38, SIZE_WORD, 1'b0, 1'b0, 32'h0001_0000);
    chk(32'(addr_error), 32'h1);
    job(6'h38, SIZE_BYTE, 1'b0, 1'b1, 32'h0003_0000);
    chk({15'h0000, addr_error, bus_wdata}, 32'h0000_3C3C);
    job(6'h10, SIZE_LONG, 1'b1, 1'b0, 32'h0);
    chk(ea_addr, 32'h0000_4000);
    op_state_reg <= 1'b1;
    job(6'h3C, SIZE_WORD, 1'b0, 1'b0, 32'h0);
    chk({status_sel, 31'(ext_i)}, 32'h8000_0000);
    $display("test faults end");
  endtask : t_faults
  initial
  begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    t_regs();
    t_modes();
    t_stack();
    t_faults();
    conclude();
  end
endmodule : operand_address_generation_bench
bind operand_address_generation oag_monitor MON (.clk, .rst_b, .start, .op_word, .op_jump, .bus_req,
  .bus_write, .bus_addr, .bus_upper, .bus_lower, .bus_program, .bus_ack, .done, .ea_illegal, .ref_program);
